// *** core/arc_regs.sv ***
`timescale 1ns/1ps
module arc_regs #(
   parameter int NUM_PINS = 8
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // converter core side
   input wire logic conv_done_in,
   input wire logic [10:0] conv_raw_in,
   output logic low_power_out,
   output logic [1:0] clock_divide_out,
   output logic long_sample_out,
   output logic [1:0] mode_out,
   output logic [1:0] input_clock_out,
   output logic converter_clock_en_out,
   output logic result_locked_out,
   // port pins
   input wire logic [NUM_PINS-1:0] pin_level_in,
   input wire logic [NUM_PINS-1:0] port_out_in,
   input wire logic [NUM_PINS-1:0] port_oe_in,
   input wire logic [NUM_PINS-1:0] port_pullup_in,
   output logic [NUM_PINS-1:0] pin_out_out,
   output logic [NUM_PINS-1:0] pin_oe_out,
   output logic [NUM_PINS-1:0] pin_pullup_out,
   output logic [NUM_PINS-1:0] port_read_out
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] res_high_q, res_high_d;
   logic [7:0] res_low_q, res_low_d;
   logic [7:0] cmp_high_q, cmp_high_d;
   logic [7:0] cmp_low_q, cmp_low_d;
   logic [7:0] cfg_q, cfg_d;
   logic [NUM_PINS-1:0] pin_dis_q, pin_dis_d;
   logic [1:0] cmp_ctrl_q, cmp_ctrl_d;
   logic lock_q, lock_d;
   logic [31:0] rdata_q, rdata_d;
   logic [3:0] clk_cnt_q, clk_cnt_d;
   logic half_q, half_d;
   arc_pkg::arc_cfg_t cfg;
   logic acc_wr, acc_rd, mode10;
   logic [10:0] rounded;
   logic [9:0] result, cmp_val;
   logic cmp_true, take;
   logic rd_setup;
   logic [NUM_PINS-1:0] pin_s1_q, pin_s1_d;
   logic [NUM_PINS-1:0] pin_s2_q, pin_s2_d;
   logic [NUM_PINS-1:0] pin_s3_q, pin_s3_d;
   logic [NUM_PINS-1:0] pin_lvl_q, pin_lvl_d;

   assign cfg = arc_pkg::arc_cfg_t'(cfg_q);
   assign mode10 = (cfg.mode_select == arc_pkg::ARC_MODE_10BIT);
   // apb: zero wait states, every access in one access phase
   assign acc_wr = psel_in & penable_in & pwrite_in;
   assign acc_rd = psel_in & penable_in & ~pwrite_in;
   assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
   assign pready_out = 1'b1;
   assign pslverr_out = 1'b0;
   assign prdata_out = rdata_q;

   // ----------------------------------------
   // rounding and compare
   // ----------------------------------------
   // half-lsb add, saturated so full scale does not wrap to zero
   always_comb
   begin
      rounded = conv_raw_in + (mode10 ? arc_pkg::ARC_ROUND_10 : arc_pkg::ARC_ROUND_8);
      if (rounded < conv_raw_in)
      begin
         rounded = arc_pkg::ARC_RAW_MAX;
      end
      result = mode10 ? rounded[10:1] : {2'b00, rounded[10:3]};
      cmp_val = mode10 ? {cmp_high_q[1:0], cmp_low_q} : {2'b00, cmp_low_q};
      cmp_true = cmp_ctrl_q[arc_pkg::ARC_CTRL_GREATER_BIT] ? (result >= cmp_val)
                                                           : (result < cmp_val);
      // lock only holds in 10-bit mode; dropped results are never queued
      take = conv_done_in & ~(mode10 & lock_q)
             & (~cmp_ctrl_q[arc_pkg::ARC_CTRL_ENABLE_BIT] | cmp_true);
   end

   // ----------------------------------------
   // register file next state
   // ----------------------------------------
   // software writes only low byte lane; read data latched in setup phase
   always_comb
   begin
      res_high_d = res_high_q;
      res_low_d = res_low_q;
      cmp_high_d = cmp_high_q;
      cmp_low_d = cmp_low_q;
      cfg_d = cfg_q;
      pin_dis_d = pin_dis_q;
      cmp_ctrl_d = cmp_ctrl_q;
      lock_d = lock_q;
      rdata_d = rdata_q;
      if (take)
      begin
         res_high_d = {6'h00, result[9:8]};
         res_low_d = result[7:0];
      end
      if (acc_wr && pstrb_in[0])
      begin
         unique case (paddr_in)
            arc_pkg::ARC_OFS_CMP_HIGH: cmp_high_d = {6'h00, pwdata_in[1:0]};
            arc_pkg::ARC_OFS_CMP_LOW: cmp_low_d = pwdata_in[7:0];
            arc_pkg::ARC_OFS_CONFIG: cfg_d = pwdata_in[7:0];
            arc_pkg::ARC_OFS_PIN_DIS: pin_dis_d = pwdata_in[NUM_PINS-1:0];
            arc_pkg::ARC_OFS_CMP_CTRL: cmp_ctrl_d = pwdata_in[1:0];
            default: ;
         endcase
      end
      // read data is latched in the setup phase so that it stands
      // through the access phase, where the master takes it
      if (rd_setup)
      begin
         unique case (paddr_in)
            arc_pkg::ARC_OFS_RESULT_HIGH: rdata_d = {24'h000000, res_high_q};
            arc_pkg::ARC_OFS_RESULT_LOW: rdata_d = {24'h000000, res_low_q};
            arc_pkg::ARC_OFS_CMP_HIGH: rdata_d = {24'h000000, cmp_high_q};
            arc_pkg::ARC_OFS_CMP_LOW: rdata_d = {24'h000000, cmp_low_q};
            arc_pkg::ARC_OFS_CONFIG: rdata_d = {24'h000000, cfg_q};
            arc_pkg::ARC_OFS_PIN_DIS: rdata_d = {{(32-NUM_PINS){1'b0}}, pin_dis_q};
            arc_pkg::ARC_OFS_CMP_CTRL: rdata_d = {30'h00000000, cmp_ctrl_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
      // the lock side effects fire once, at the access edge
      if (acc_rd && (paddr_in == arc_pkg::ARC_OFS_RESULT_HIGH) && mode10)
      begin
         lock_d = 1'b1;
      end
      if (acc_rd && (paddr_in == arc_pkg::ARC_OFS_RESULT_LOW))
      begin
         lock_d = 1'b0;
      end
      // leaving 10-bit mode must not leave a stale lock behind
      if (!mode10)
      begin
         lock_d = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         res_high_q <= arc_pkg::ARC_BYTE_RESET;
         res_low_q <= arc_pkg::ARC_BYTE_RESET;
         cmp_high_q <= arc_pkg::ARC_BYTE_RESET;
         cmp_low_q <= arc_pkg::ARC_BYTE_RESET;
         cfg_q <= arc_pkg::ARC_CONFIG_RESET;
         pin_dis_q <= '0;
         cmp_ctrl_q <= 2'h0;
         lock_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         res_high_q <= res_high_d;
         res_low_q <= res_low_d;
         cmp_high_q <= cmp_high_d;
         cmp_low_q <= cmp_low_d;
         cfg_q <= cfg_d;
         pin_dis_q <= pin_dis_d;
         cmp_ctrl_q <= cmp_ctrl_d;
         lock_q <= lock_d;
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------
   // converter clock enable from bus clock
   // ----------------------------------------
   // only the bus-clock sources are divided here; the alternate and
   // internal async sources are divided inside the analog core
   always_comb
   begin
      half_d = ~half_q;
      clk_cnt_d = clk_cnt_q;
      if ((cfg.input_clock_select == 2'h0) || half_q)
      begin
         clk_cnt_d = clk_cnt_q + 4'h1;
      end
      if (clk_cnt_d >= (4'h1 << cfg.clock_divide_select))
      begin
         clk_cnt_d = 4'h0;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         clk_cnt_q <= 4'h0;
         half_q <= 1'b0;
      end
      else
      begin
         clk_cnt_q <= clk_cnt_d;
         half_q <= half_d;
      end
   end

   assign converter_clock_en_out = (cfg.input_clock_select[1] == 1'b0)
                                   && ((cfg.input_clock_select == 2'h0) || half_q)
                                   && (clk_cnt_d == 4'h0);
   assign low_power_out = cfg.low_power_select;
   assign clock_divide_out = cfg.clock_divide_select;
   assign long_sample_out = cfg.long_sample_select;
   assign mode_out = cfg.mode_select;
   assign input_clock_out = cfg.input_clock_select;
   assign result_locked_out = lock_q;

   // ----------------------------------------
   // pin level synchroniser
   // ----------------------------------------
   // pins are asynchronous; a level counts only once stages two and
   // three agree, trading four cycles of latency for glitch immunity
   always_comb
   begin
      pin_s1_d = pin_level_in;
      pin_s2_d = pin_s1_q;
      pin_s3_d = pin_s2_q;
      pin_lvl_d = pin_lvl_q;
      for (int i = 0; i < NUM_PINS; i++)
      begin
         if (pin_s2_q[i] == pin_s3_q[i])
         begin
            pin_lvl_d[i] = pin_s3_q[i];
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
         pin_lvl_q <= '0;
      end
      else
      begin
         pin_s1_q <= pin_s1_d;
         pin_s2_q <= pin_s2_d;
         pin_s3_q <= pin_s3_d;
         pin_lvl_q <= pin_lvl_d;
      end
   end

   // ----------------------------------------
   // pin gating
   // ----------------------------------------
   // a disabled pin has no output data, no enable and no pullup
   assign pin_out_out = port_out_in & ~pin_dis_q;
   assign pin_oe_out = port_oe_in & ~pin_dis_q;
   assign pin_pullup_out = port_pullup_in & ~pin_dis_q;
   assign port_read_out = pin_lvl_q & ~pin_dis_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_high_zero_8bit;
      @(posedge clk_in) disable iff (!reset_n_in)
      (take && !mode10) |=> (res_high_q == 8'h00);
   endproperty
   a_high_zero_8bit: assert property (p_high_zero_8bit) else $error("high not zero");

   property p_low_loaded;
      @(posedge clk_in) disable iff (!reset_n_in)
      take |=> (res_low_q == $past(result[7:0]));
   endproperty
   a_low_loaded: assert property (p_low_loaded) else $error("low not loaded");

   property p_cmp_hold;
      @(posedge clk_in) disable iff (!reset_n_in)
      (conv_done_in && cmp_ctrl_q[0] && !cmp_true) |=> $stable(res_low_q) && $stable(res_high_q);
   endproperty
   a_cmp_hold: assert property (p_cmp_hold) else $error("compare false updated");

   property p_lock_hold;
      @(posedge clk_in) disable iff (!reset_n_in)
      (lock_q && mode10 && !(acc_wr && pstrb_in[0])) |=> $stable(res_low_q);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("locked result moved");

   property p_lock_set;
      @(posedge clk_in) disable iff (!reset_n_in)
      (acc_rd && paddr_in == arc_pkg::ARC_OFS_RESULT_HIGH && mode10) |=> lock_q;
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("no lock after high read");

   property p_no_lock_8bit;
      @(posedge clk_in) disable iff (!reset_n_in)
      (conv_done_in && !mode10 && !cmp_ctrl_q[0]) |-> take;
   endproperty
   a_no_lock_8bit: assert property (p_no_lock_8bit) else $error("8-bit dropped");

   property p_pin_dis;
      @(posedge clk_in) disable iff (!reset_n_in)
      (pin_dis_q != '0) |-> ((pin_oe_out & pin_dis_q) == '0) && ((port_read_out & pin_dis_q) == '0);
   endproperty
   a_pin_dis: assert property (p_pin_dis) else $error("disabled pin active");

   property p_cfg_field;
      @(posedge clk_in) disable iff (!reset_n_in)
      (acc_wr && pstrb_in[0] && paddr_in == arc_pkg::ARC_OFS_CONFIG)
      |=> (mode_out == $past(pwdata_in[3:2])) && (low_power_out == $past(pwdata_in[7]));
   endproperty
   a_cfg_field: assert property (p_cfg_field) else $error("config field wrong");

   // a read transfer: setup phase, then its access phase
   sequence s_rd_setup;
      psel_in && !penable_in && !pwrite_in;
   endsequence

   sequence s_rd_access;
      psel_in && penable_in && !pwrite_in;
   endsequence

   property p_rd_stands;
      @(posedge clk_in) disable iff (!reset_n_in)
      s_rd_setup ##1 s_rd_access |=> $stable(prdata_out);
   endproperty
   a_rd_stands: assert property (p_rd_stands) else $error("read data moved");

   property p_high_upper;
      @(posedge clk_in) disable iff (!reset_n_in)
      (take && mode10) |=> (res_high_q == {6'h00, $past(result[9:8])});
   endproperty
   a_high_upper: assert property (p_high_upper) else $error("high bits wrong");

   property p_lock_clear;
      @(posedge clk_in) disable iff (!reset_n_in)
      (acc_rd && paddr_in == arc_pkg::ARC_OFS_RESULT_LOW) |=> !lock_q;
   endproperty
   a_lock_clear: assert property (p_lock_clear) else $error("lock kept");

   property p_lock_drop;
      @(posedge clk_in) disable iff (!reset_n_in)
      (conv_done_in && lock_q && mode10) |=> $stable(res_high_q);
   endproperty
   a_lock_drop: assert property (p_lock_drop) else $error("locked high moved");

   property p_mode8_unlock;
      @(posedge clk_in) disable iff (!reset_n_in)
      !mode10 |=> !lock_q;
   endproperty
   a_mode8_unlock: assert property (p_mode8_unlock) else $error("lock in 8-bit");

   property p_cmp_off_take;
      @(posedge clk_in) disable iff (!reset_n_in)
      (conv_done_in && !cmp_ctrl_q[0] && !(mode10 && lock_q)) |-> take;
   endproperty
   a_cmp_off_take: assert property (p_cmp_off_take) else $error("result skipped");

   property p_cfg_rest;
      @(posedge clk_in) disable iff (!reset_n_in)
      (acc_wr && pstrb_in[0] && paddr_in == arc_pkg::ARC_OFS_CONFIG)
      |=> (clock_divide_out == $past(pwdata_in[6:5])) && (input_clock_out == $past(pwdata_in[1:0]));
   endproperty
   a_cfg_rest: assert property (p_cfg_rest) else $error("config clock wrong");

   property p_async_src;
      @(posedge clk_in) disable iff (!reset_n_in)
      input_clock_out[1] |-> !converter_clock_en_out;
   endproperty
   a_async_src: assert property (p_async_src) else $error("tick on foreign source");

   property p_div1_tick;
      @(posedge clk_in) disable iff (!reset_n_in)
      (input_clock_out == 2'h0 && clock_divide_out == 2'h0) |-> converter_clock_en_out;
   endproperty
   a_div1_tick: assert property (p_div1_tick) else $error("divide by one missed");

   property p_pin_drive;
      @(posedge clk_in) disable iff (!reset_n_in)
      (((pin_out_out | pin_pullup_out) & pin_dis_q) == '0);
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("disabled pin driven");
endmodule // arc_regs

// *** core/arc_pkg.sv ***
//
// Notes on behaviour
// - high result holds bits 9:8, zero in 8-bit
// - low result holds low eight bits
// - compare-false completion leaves both results unchanged
// - 10-bit high read locks results until low read
// - completions while locked are dropped, not queued
// - 8-bit mode has no read interlock
// - 10-bit compare uses high compare bits 1:0
// - 8-bit compare ignores high compare register
// - low compare byte meets low result byte
// - config bit 7 selects low power
// - bits 6:5 divide input clock 1/2/4/8
// - config bit 4 selects long sample
// - bits 3:2 select 8-bit or 10-bit
// - bits 1:0 select converter input clock
// - pin-disable bit n governs channel n pin
// - disabled pin: hi-z, input zero, no pullup
// - round raw result to 10 or 8 bits
// - compare less-than, or greater-equal when selected
package arc_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] ARC_OFS_RESULT_HIGH = 8'h00;
   localparam logic [7:0] ARC_OFS_RESULT_LOW = 8'h04;
   localparam logic [7:0] ARC_OFS_CMP_HIGH = 8'h08;
   localparam logic [7:0] ARC_OFS_CMP_LOW = 8'h0C;
   localparam logic [7:0] ARC_OFS_CONFIG = 8'h10;
   localparam logic [7:0] ARC_OFS_PIN_DIS = 8'h14;
   localparam logic [7:0] ARC_OFS_CMP_CTRL = 8'h18;
   // ----------------------------------------
   // field positions and codes
   // ----------------------------------------
   localparam int ARC_CFG_LOW_POWER_BIT = 7;
   localparam int ARC_CFG_DIV_LSB = 5;
   localparam int ARC_CFG_LONG_SAMPLE_BIT = 4;
   localparam int ARC_CFG_MODE_LSB = 2;
   localparam int ARC_CFG_CLK_LSB = 0;
   localparam int ARC_CTRL_ENABLE_BIT = 0;
   localparam int ARC_CTRL_GREATER_BIT = 1;
   localparam logic [1:0] ARC_MODE_8BIT = 2'h0;
   localparam logic [1:0] ARC_MODE_10BIT = 2'h2;
   localparam logic [7:0] ARC_CONFIG_RESET = 8'h00;
   localparam logic [7:0] ARC_BYTE_RESET = 8'h00;
   localparam logic [10:0] ARC_ROUND_10 = 11'h001;
   localparam logic [10:0] ARC_ROUND_8 = 11'h004;
   localparam logic [10:0] ARC_RAW_MAX = 11'h7FF;

   // decoded configuration fields
   typedef struct packed {
      logic low_power_select;
      logic [1:0] clock_divide_select;
      logic long_sample_select;
      logic [1:0] mode_select;
      logic [1:0] input_clock_select;
   } arc_cfg_t;
endpackage

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module tb_top;
   // ----------------------------------------
   // stimulus signals and design
   // ----------------------------------------
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic conv_done = 1'b0;
   logic [10:0] conv_raw = 11'h000;
   logic [7:0] pins = 8'hFF;
   logic [31:0] prdata;
   logic pready;
   logic perr;
   logic [31:0] rd_q = 32'h00000000;
   logic lp, ls, ce, lk;
   logic [1:0] dv, md, ck;
   logic [7:0] po, poe, ppu, prd;
   int failures = 0;
   int n_checks = 0;
   arc_regs arc_regs_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pstrb_in(4'h1), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
      .conv_done_in(conv_done), .conv_raw_in(conv_raw), .low_power_out(lp),
      .clock_divide_out(dv), .long_sample_out(ls), .mode_out(md), .input_clock_out(ck),
      .converter_clock_en_out(ce), .result_locked_out(lk), .pin_level_in(pins),
      .port_out_in(pins), .port_oe_in(pins), .port_pullup_in(pins), .pin_out_out(po),
      .pin_oe_out(poe), .pin_pullup_out(ppu), .port_read_out(prd));
   // free-running 100 MHz clock
   initial forever #5 clk_in = ~clk_in;
   // ----------------------------------------
   // bus and converter tasks
   // ----------------------------------------
   // request held until pready is seen high at an edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk_in);
      penable <= 1'b1;
      do @(posedge clk_in); while (pready !== 1'b1);
      rd_q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next call never re-drives psel in this step
      @(posedge clk_in);
   endtask
   // read data is taken at the completing edge
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      apb(a, 1'b0, 8'h00);
      `CHK(rd_q[7:0], e)
      `CHK({rd_q[31:8], perr}, 25'h0)
   endtask
   task automatic conv(input logic [10:0] r);
      conv_done <= 1'b1;
      conv_raw <= r;
      @(posedge clk_in);
      conv_done <= 1'b0;
   endtask
   // converter ticks over 16 cycles for one configuration
   task automatic tick(input logic [7:0] cfg, input int e);
      int n;
      n = 0;
      apb(arc_pkg::ARC_OFS_CONFIG, 1'b1, cfg);
      @(posedge clk_in);
      repeat (16)
      begin
         @(posedge clk_in);
         n += int'(ce === 1'b1);
      end
      `CHK(n, e)
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      for (int i = 0; i < 8; i++) rc(8'(4 * i), 8'h00);
      apb(arc_pkg::ARC_OFS_CONFIG, 1'b1, 8'hD9);
      @(posedge clk_in);
      `CHK({lp, dv, ls, md, ck}, 8'hD9)
      tick(8'h00, 16);
      tick(8'h20, 8);
      tick(8'h40, 4);
      tick(8'h60, 2);
      tick(8'h01, 8);
      tick(8'h02, 0);
      tick(8'h03, 0);
      apb(arc_pkg::ARC_OFS_PIN_DIS, 1'b1, 8'hA5);
      @(posedge clk_in);
      `CHK({po, poe, ppu, prd}, {4{8'h5A}})
   endtask
   // 8-bit: high forced zero, rounding, no interlock
   task automatic t_res8();
      apb(arc_pkg::ARC_OFS_CONFIG, 1'b1, 8'h00);
      conv(11'h7FF);
      rc(arc_pkg::ARC_OFS_RESULT_HIGH, 8'h00);
      rc(arc_pkg::ARC_OFS_RESULT_LOW, 8'hFF);
      conv(11'h11C);
      rc(arc_pkg::ARC_OFS_RESULT_HIGH, 8'h00);
      conv(11'h104);
      rc(arc_pkg::ARC_OFS_RESULT_LOW, 8'h21);
   endtask
   // 10-bit: high read locks, further result dropped, low read frees
   task automatic t_lock();
      apb(arc_pkg::ARC_OFS_CONFIG, 1'b1, 8'h08);
      conv(11'h5A7);
      rc(arc_pkg::ARC_OFS_RESULT_HIGH, 8'h02);
      `CHK(lk, 1'b1)
      conv(11'h0C8);
      apb(arc_pkg::ARC_OFS_RESULT_LOW, 1'b1, 8'h00);
      rc(arc_pkg::ARC_OFS_RESULT_LOW, 8'hD4);
      conv(11'h0C8);
      rc(arc_pkg::ARC_OFS_RESULT_HIGH, 8'h00);
      rc(arc_pkg::ARC_OFS_RESULT_LOW, 8'h64);
   endtask
   // compare gates the update, both polarities, high byte only in 10-bit
   task automatic t_cmp();
      apb(arc_pkg::ARC_OFS_CMP_HIGH, 1'b1, 8'h01);
      apb(arc_pkg::ARC_OFS_CMP_LOW, 1'b1, 8'h00);
      apb(arc_pkg::ARC_OFS_CMP_CTRL, 1'b1, 8'h01);
      conv(11'h1FE);
      rc(arc_pkg::ARC_OFS_RESULT_LOW, 8'hFF);
      conv(11'h400);
      rc(arc_pkg::ARC_OFS_RESULT_HIGH, 8'h00);
      rc(arc_pkg::ARC_OFS_RESULT_LOW, 8'hFF);
      apb(arc_pkg::ARC_OFS_CMP_CTRL, 1'b1, 8'h03);
      conv(11'h200);
      rc(arc_pkg::ARC_OFS_RESULT_HIGH, 8'h01);
      rc(arc_pkg::ARC_OFS_RESULT_LOW, 8'h00);
      conv(11'h1FE);
      rc(arc_pkg::ARC_OFS_RESULT_LOW, 8'h00);
      apb(arc_pkg::ARC_OFS_CONFIG, 1'b1, 8'h00); // no result read before a new conversion
      apb(arc_pkg::ARC_OFS_CMP_LOW, 1'b1, 8'h80);
      conv(11'h480);
      rc(arc_pkg::ARC_OFS_RESULT_LOW, 8'h90);
      conv(11'h200);
      rc(arc_pkg::ARC_OFS_RESULT_LOW, 8'h90);
   endtask
   // ----------------------------------------
   // verdict and main sequence
   // ----------------------------------------
   task automatic end_sim();
      if (failures == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // watchdog well beyond the few hundred cycles the run needs
   initial
   begin
      #200000;
      failures++;
      end_sim();
   end
   initial
   begin
      repeat (8) @(posedge clk_in);
      reset_n_in <= 1'b1;
      @(posedge clk_in);
      t_regs();
      t_res8();
      t_lock();
      t_cmp();
      end_sim();
   end
endmodule // tb_top
